// *** core/fifo_cascade_expansion.v ***
/*
 * Depth-expanded chain of fall-through FIFO stages with status flags.
 * Assumes write_en_n and read_en_n come from logic on sys_clk.
 */
// Function
// - Near-drained flag lifts one cycle after write
// - Stage holds one word beyond memory depth
// - Ready flags may differ one cycle across group
// - Chain capacity sums all stage depths
// - First word falls through without read
// - Valid output word drives out-ready low
// - Ripple: (N-1)*4 plus 3 cycles
// - Only first word sees ripple delay
// - Freed location drives space-available low
// - Bubble: (N-1)*3 plus 2 cycles
// - Over-middle low above half, high at half
`timescale 1ns/1ps
`default_nettype none
`include "fifo_cascade_map.vh"

module fifo_stage #(
    parameter WIDTH = `CASC_WIDTH,
    parameter AW = `CASC_ADDR_BITS,
    parameter NEAR_OFS = `CASC_NEAR_OFS
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg space_avail_n,
    output reg out_ready_n,
    output reg [WIDTH-1:0] out_data,
    output reg over_middle_n,
    output reg near_drained_n
);
    localparam PW = AW + 2;
    localparam [31:0] DEPTH = 32'h1 << AW;
    localparam [31:0] CAP_WORD = DEPTH + 32'h1;
    localparam [31:0] HALF_WORD = DEPTH / 32'h2 + 32'h1;
    localparam [31:0] NEAR_WORD = NEAR_OFS + 1;
    localparam [PW-1:0] CAP = CAP_WORD[PW-1:0];
    localparam [PW-1:0] HALF_MARK = HALF_WORD[PW-1:0];
    localparam [PW-1:0] NEAR_MARK = NEAR_WORD[PW-1:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PW-1:0] wr_ptr;
    reg [PW-1:0] rd_ptr;
    reg [PW-1:0] pop_ptr;
    reg [PW-1:0] wr_vis1;
    reg [PW-1:0] wr_vis;
    reg [PW-1:0] pop_vis;
    reg out_valid;

    wire wr_take;
    wire pop;
    wire fetch;
    wire [PW-1:0] next_wr;
    wire [PW-1:0] next_pop;
    wire [PW-1:0] next_occ;
    wire [PW-1:0] next_occ_w;
    wire [PW-1:0] next_occ_r;

    assign wr_take = wr_en & ~space_avail_n;
    assign pop = rd_en & out_valid;
    assign fetch = (wr_vis != rd_ptr) & (~out_valid | pop);
    assign next_wr = wr_ptr + {{(PW-1){1'b0}}, wr_take};
    assign next_pop = pop_ptr + {{(PW-1){1'b0}}, pop};
    assign next_occ = next_wr - next_pop;
    assign next_occ_w = next_wr - pop_vis;
    // Read side sees a write one edge late
    assign next_occ_r = wr_ptr - next_pop;

    always @(posedge sys_clk) begin
        if (wr_take) begin
            mem[wr_ptr[AW-1:0]] <= wr_data;
        end
        if (fetch) begin
            out_data <= mem[rd_ptr[AW-1:0]];
        end
    end

    // Pointer counters
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {PW{1'b0}};
            rd_ptr <= {PW{1'b0}};
            pop_ptr <= {PW{1'b0}};
        end else begin
            wr_ptr <= next_wr;
            pop_ptr <= next_pop;
            if (fetch) begin
                rd_ptr <= rd_ptr + {{(PW-1){1'b0}}, 1'b1};
            end
        end
    end

    // One clock, each side sees the other's pointer late
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_vis1 <= {PW{1'b0}};
            wr_vis <= {PW{1'b0}};
            pop_vis <= {PW{1'b0}};
        end else begin
            // Write seen on read side two edges later
            wr_vis1 <= wr_ptr;
            wr_vis <= wr_vis1;
            // Pop seen on write side one edge later
            pop_vis <= pop_ptr;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_ready_n <= `CASC_READY_RST;
        end else if (fetch) begin
            out_valid <= 1'b1;
            out_ready_n <= 1'b0;
        end else if (pop) begin
            out_valid <= 1'b0;
            out_ready_n <= 1'b1;
        end
    end

    // Status flags
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            space_avail_n <= `CASC_SPACE_RST;
            over_middle_n <= `CASC_MIDDLE_RST;
            near_drained_n <= `CASC_DRAINED_RST;
        end else begin
            space_avail_n <= (next_occ_w >= CAP);
            over_middle_n <= ~(next_occ > HALF_MARK);
            near_drained_n <= ~(next_occ_r <= NEAR_MARK);
        end
    end
endmodule // fifo_stage

module fifo_cascade_expansion #(
    parameter STAGES = `CASC_STAGES,
    parameter WIDTH = `CASC_WIDTH,
    parameter AW = `CASC_ADDR_BITS,
    parameter NEAR_OFS = `CASC_NEAR_OFS
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] data_in,
    input wire write_en_n,
    input wire read_en_n,
    output wire [WIDTH-1:0] data_out,
    output wire space_avail_flag_n,
    output wire out_ready_n,
    output wire over_middle_flag_n,
    output wire near_drained_flag_n
);
    wire [WIDTH*STAGES-1:0] st_din;
    wire [WIDTH*STAGES-1:0] st_dout;
    wire [STAGES-1:0] st_wr;
    wire [STAGES-1:0] st_rd;
    wire [STAGES-1:0] st_space_n;
    wire [STAGES-1:0] st_ready_n;
    wire [STAGES-1:0] st_middle_n;
    wire [STAGES-1:0] st_drained_n;

    assign st_din[WIDTH-1:0] = data_in;
    assign st_wr[0] = ~write_en_n;
    assign st_rd[STAGES-1] = ~read_en_n;

    genvar k;
    generate
        for (k = 0; k < STAGES; k = k + 1) begin : g_stage
            fifo_stage #(
                .WIDTH(WIDTH),
                .AW(AW),
                .NEAR_OFS(NEAR_OFS)
            ) u_stage (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .wr_data(st_din[WIDTH*k +: WIDTH]),
                .wr_en(st_wr[k]),
                .rd_en(st_rd[k]),
                .space_avail_n(st_space_n[k]),
                .out_ready_n(st_ready_n[k]),
                .out_data(st_dout[WIDTH*k +: WIDTH]),
                .over_middle_n(st_middle_n[k]),
                .near_drained_n(st_drained_n[k])
            );
            if (k < STAGES - 1) begin : g_link
                // Later words pass one per edge
                assign st_wr[k+1] = ~st_ready_n[k] & ~st_space_n[k+1];
                assign st_rd[k] = ~st_ready_n[k] & ~st_space_n[k+1];
                assign st_din[WIDTH*(k+1) +: WIDTH] = st_dout[WIDTH*k +: WIDTH];
            end
        end
    endgenerate

    assign data_out = st_dout[WIDTH*(STAGES-1) +: WIDTH];
    assign space_avail_flag_n = st_space_n[0];
    assign out_ready_n = st_ready_n[STAGES-1];
    assign over_middle_flag_n = st_middle_n[STAGES-1];
    assign near_drained_flag_n = st_drained_n[STAGES-1];
endmodule // fifo_cascade_expansion
`default_nettype wire

// *** core/fifo_cascade_map.vh ***
/*
 * Constants for the cascaded fall-through FIFO chain.
 * Assumes one clock drives write, read and transfer sides alike.
 */
`ifndef FIFO_CASCADE_MAP_VH
`define FIFO_CASCADE_MAP_VH

// Default chain shape
`define CASC_STAGES 2
`define CASC_WIDTH 18
`define CASC_ADDR_BITS 17
`define CASC_NEAR_OFS 7

// Clock period, ns
`define CASC_CLK_PERIOD_NS 4

// Flag values held during reset
`define CASC_SPACE_RST 1'b0
`define CASC_READY_RST 1'b1
`define CASC_MIDDLE_RST 1'b1
`define CASC_DRAINED_RST 1'b0

`endif

// *** verification/fifo_cascade_expansion_monitor.sv ***
/* Port checker for the cascade chain.
   Assumes one clock and a two-stage chain. */
`timescale 1ns/1ps
`default_nettype none
module fifo_cascade_expansion_monitor #(
    parameter STAGES = 2,
    parameter WIDTH = 18,
    parameter AW = 17,
    parameter NEAR_OFS = 7
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic [WIDTH-1:0] data_out,
    input wire logic space_avail_flag_n,
    input wire logic out_ready_n,
    input wire logic over_middle_flag_n,
    input wire logic near_drained_flag_n
);
    localparam int CAP = STAGES * (2 ** AW + 1);
    int cnt;
    wire logic wt = !write_en_n && !space_avail_flag_n;
    wire logic rt = !read_en_n && !out_ready_n;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cnt <= 0;
        else cnt <= cnt + (wt ? 1 : 0) - (rt ? 1 : 0);
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RIPPLE: assert property (cnt == 0 && wt |=> out_ready_n [*7] ##1 !out_ready_n)
        else $error("ripple latency");
    AST_BUBBLE: assert property (cnt == CAP && rt |=>
        space_avail_flag_n [*5] ##1 !space_avail_flag_n) else $error("bubble latency");
    AST_EMPTY: assert property (cnt == 0 |->
        out_ready_n && over_middle_flag_n && !near_drained_flag_n) else $error("empty flags");
    AST_FULL: assert property (cnt == CAP |->
        space_avail_flag_n && !over_middle_flag_n) else $error("full flags");
    AST_CAP: assert property (space_avail_flag_n |-> cnt >= 2 ** AW + 1)
        else $error("space refused early");
    AST_STAND: assert property (!out_ready_n && read_en_n |=>
        !out_ready_n && $stable(data_out)) else $error("head word moved");
    AST_POP: assert property (cnt == CAP && rt |=> !out_ready_n)
        else $error("next word late");
    AST_RST: assert property ($rose(rst_n) |-> !space_avail_flag_n && out_ready_n)
        else $error("reset flags");
endmodule // fifo_cascade_expansion_monitor
bind fifo_cascade_expansion fifo_cascade_expansion_monitor #(.STAGES(STAGES), .WIDTH(WIDTH),
    .AW(AW), .NEAR_OFS(NEAR_OFS)) i_mon (.sys_clk(sys_clk), .rst_n(rst_n),
    .write_en_n(write_en_n), .read_en_n(read_en_n), .data_out(data_out),
    .space_avail_flag_n(space_avail_flag_n), .out_ready_n(out_ready_n),
    .over_middle_flag_n(over_middle_flag_n), .near_drained_flag_n(near_drained_flag_n));
`default_nettype wire

// *** verification/fifo_reader.sv ***
/* Reader model on the chain output.
   Assumes go and slow change off the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module fifo_reader (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic slow,
    output var logic read_en_n
);
    logic ph = 1'b0;
    always @(negedge sys_clk) begin
        ph <= ~ph;
        read_en_n <= ~(go & (~slow | ph));
    end
endmodule // fifo_reader
`default_nettype wire

// *** verification/test_fifo_cascade_expansion.sv ***
/* Bench: ripple, fill, bubble, drain.
   Assumes the reader model on the output. */
`timescale 1ns/1ps
`default_nettype none
module test_fifo_cascade_expansion;
    logic sys_clk = 0, rst_n = 0, write_en_n = 1, go = 0, slow = 0, t;
    logic [17:0] data_in = 18'h00000, q[$];
    wire logic [17:0] data_out;
    wire logic read_en_n, space_n, ready_n, middle_n, drained_n;
    int err_count = 0, cmp_count = 0, n;
    always #2 sys_clk = ~sys_clk;
    fifo_cascade_expansion #(.STAGES(2), .AW(2), .NEAR_OFS(1)) i_fifo_cascade_expansion (
        .sys_clk(sys_clk), .rst_n(rst_n), .data_in(data_in), .write_en_n(write_en_n),
        .read_en_n(read_en_n), .data_out(data_out), .space_avail_flag_n(space_n),
        .out_ready_n(ready_n), .over_middle_flag_n(middle_n), .near_drained_flag_n(drained_n));
    fifo_reader i_fifo_reader (.sys_clk(sys_clk), .go(go), .slow(slow), .read_en_n(read_en_n));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [17:0] d);
        @(negedge sys_clk);
        write_en_n = 0;
        data_in = d;
        t = !space_n;
        if (t) q.push_back(d);
        @(posedge sys_clk);
        @(negedge sys_clk);
        write_en_n = 1;
    endtask
    task edges(input bit sp);
        n = 0;
        while ((sp ? space_n : ready_n) !== 1'b0 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task close_out;
        $display("Compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk)
        if (rst_n && !read_en_n && !ready_n) chk("data_out", q.pop_front(), data_out);
    initial begin
        #4000;
        err_count++;
        close_out;
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1;
        wr(18'h00101);
        edges(0);
        chk("ripple", 7, n);
        chk("first word", 18'h00101, data_out);
        for (int i = 0; i < 12 && (i == 0 || t); i++) wr(18'h00200 + i);
        repeat (3) @(negedge sys_clk);
        chk("capacity", 10, q.size());
        chk("over_middle", 0, middle_n);
        chk("near_drained", 1, drained_n);
        @(negedge sys_clk);
        go <= 1;
        @(negedge sys_clk);
        go <= 0;
        @(negedge sys_clk);
        edges(1);
        chk("bubble", 5, n);
        wr(18'h00300);
        chk("refill", 1, t);
        slow <= 1;
        go <= 1;
        for (int i = 0; i < 200 && q.size() > 0; i++) @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
        chk("drained", 0, q.size());
        chk("out_ready", 1, ready_n);
        chk("near_drained", 0, drained_n);
        chk("over_middle", 1, middle_n);
        close_out;
    end
endmodule // test_fifo_cascade_expansion
`default_nettype wire
